// *** osc_clock_control.sv ***
// oscillator source control: start-up, multiplier, internal sources, selection
//
// Summary of operation
// R1: crystal modes count 1024 primary pin oscillations before the clock is usable.
// R2: counting starts after reset, after power-up delay if configured, and on wake.
// R3: the processor is held while the start-up count runs.
// R4: a 4x multiplier takes an external or internal source as its input.
// R5: multiplier enabled by configuration bit or software bit; configuration overrides software.
// R6: the timer crystal oscillator is selectable at run time as system clock.
// R7: in RC mode the primary pin clocks; secondary pin is I/O or clock output.
// R8: in internal mode primary pin is released; secondary pin I/O or clock out.
// R9: the configured source select gives the default clock after any reset.
// R10: software select bits switch the system clock to the internal block.
// R11: the high source is derived from the medium source by a multiplying loop.
// R12: a low source runs independently of the two other internal sources.
// R13: a tuning register adjusts both high and medium internal sources.
// R14: a postscaler and mux pick one of nine derived frequencies.
// R15: high and medium sources enabled when selected and internal mode is active.
// R16: high ready flag shows the high source running and usable.
// R17: high locked flag shows the high source within two percent.
// R18: high stable flag shows the high source within half a percent.
// R19: medium ready flag shows the medium source running and usable.
// R20: select code 00 default, 01 timer crystal, 1x internal block.
// R21: after any reset the frequency select loads 0111, the 500 kHz choice.
// R22: frequency switch waits old falling edge, holds low, waits new rising edge.
// R23: status flags clear when their source stops and rise again after restart.
// R24: the start-up count is skipped for clock, RC and internal modes.
`timescale 1ns/1ps
`default_nettype none
module osc_clock_control
  import osc_ctrl_pkg::*;
#(
  parameter logic [7:0]  HF_READY_EDGES  = 8'h04,
  parameter logic [7:0]  HF_LOCK_EDGES   = 8'h10,
  parameter logic [7:0]  HF_STABLE_EDGES = 8'h40,
  parameter logic [7:0]  MF_READY_EDGES  = 8'h04,
  parameter logic [7:0]  LF_READY_EDGES  = 8'h02,
  parameter int unsigned START_COUNT     = STARTUP_CYCLES
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output var  logic [31:0]      wb_dat_o,
  output var  logic             wb_ack_o,
  input  wire logic [2:0]       cfg_source_select,
  input  wire logic             cfg_pll_enable,
  input  wire logic             cfg_clock_out_enable,
  input  wire logic             cfg_power_up_delay,
  input  wire logic             power_up_done,
  input  wire logic             wake_event,
  input  wire logic             primary_osc_pin,
  input  wire logic             timer_crystal_in_pin,
  input  wire logic             hf_osc_in,
  input  wire logic             mf_osc_in,
  input  wire logic             lf_osc_in,
  output var  logic             cpu_hold,
  output var  logic             hf_enable,
  output var  logic             mf_enable,
  output var  logic             lf_enable,
  output var  logic             hf_loop_enable,
  output var  logic [5:0]       osc_tune,
  output var  logic             pll_enable,
  output var  logic             pll_from_internal,
  output var  logic [1:0]       sys_clk_source,
  output var  logic             internal_clock,
  output var  logic             primary_pin_released,
  output var  logic             secondary_pin_out,
  output var  logic             secondary_pin_oe_n,
  output var  logic             secondary_pin_released
);

  if (HF_READY_EDGES > HF_LOCK_EDGES || HF_LOCK_EDGES > HF_STABLE_EDGES
      || HF_READY_EDGES == 8'h00 || MF_READY_EDGES == 8'h00 || LF_READY_EDGES == 8'h00)
  begin : g_bad_edges
    $error("settle thresholds must be nonzero and ordered");
  end

  typedef enum logic [1:0] {
    SW_IDLE       = 2'b00,
    SW_WAIT_READY = 2'b01,
    SW_WAIT_FALL  = 2'b11,
    SW_WAIT_RISE  = 2'b10
  } switch_e;

  // every oscillator input is asynchronous to clk_sys
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_sync;
  logic [PIN_N-1:0] pin_rise;
  assign pin_raw = {timer_crystal_in_pin, primary_osc_pin, lf_osc_in, mf_osc_in, hf_osc_in};

  for (genvar i = 0; i < PIN_N; i++) begin : g_sync
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        prev_reg <= 1'b0;
      end else if (ce) begin
        meta_reg <= pin_raw[i];
        sync_reg <= meta_reg;
        prev_reg <= sync_reg;
      end
    end
    assign pin_sync[i] = sync_reg;
    assign pin_rise[i] = sync_reg & ~prev_reg;
  end

  // control registers
  logic [1:0] scs_reg;
  logic [3:0] ifs_reg;
  logic       spll_reg;
  logic       bus_req;
  logic       bus_wr;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scs_reg  <= SCS_DEFAULT;
      // R21: reset frequency choice
      ifs_reg  <= IFS_RESET;
      spll_reg <= 1'b0;
      osc_tune <= TUNE_RESET;
    end else if (ce && bus_wr) begin
      if (wb_adr_i == REG_CONTROL) begin
        scs_reg  <= wb_dat_i[CTL_SCS_LSB +: 2];
        ifs_reg  <= wb_dat_i[CTL_IFS_LSB +: 4];
        spll_reg <= wb_dat_i[CTL_PLL_BIT];
      end else if (wb_adr_i == REG_TUNING) begin
        // R13: one trim for high and medium sources
        osc_tune <= wb_dat_i[5:0];
      end
    end
  end

  // source enables
  logic       int_mode;
  logic [5:0] req_route;
  logic [5:0] act_route_reg;
  logic [5:0] tgt_route_reg;
  logic       hf_need;
  logic       mf_need;
  logic       lf_need;

  assign int_mode  = scs_reg[SCS_INT_BIT] || cfg_source_select == SRC_INT;
  assign req_route = int_route(ifs_reg);
  // R15: selected source runs only in internal mode; old and target kept until switched
  assign hf_need = int_mode && (req_route[5:4] == INT_HF || act_route_reg[5:4] == INT_HF
                   || tgt_route_reg[5:4] == INT_HF);
  // R11: the high source is multiplied up from the medium one, so both run
  assign mf_need = hf_need || (int_mode
                   && (req_route[5:4] == INT_MF || act_route_reg[5:4] == INT_MF
                       || tgt_route_reg[5:4] == INT_MF));
  // R12: the low source has its own enable
  assign lf_need = int_mode && (req_route[5:4] == INT_LF || act_route_reg[5:4] == INT_LF
                   || tgt_route_reg[5:4] == INT_LF);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hf_enable      <= 1'b0;
      mf_enable      <= 1'b0;
      lf_enable      <= 1'b0;
      hf_loop_enable <= 1'b0;
    end else if (ce) begin
      hf_enable      <= hf_need;
      mf_enable      <= mf_need;
      lf_enable      <= lf_need;
      hf_loop_enable <= hf_need;
    end
  end

  // settle counters: oscillations seen since enable, saturating
  logic [2:0] src_en;
  logic [7:0] settle_cnt [3];
  assign src_en = {lf_enable, mf_enable, hf_enable};

  for (genvar s = 0; s < 3; s++) begin : g_settle
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        settle_cnt[s] <= 8'h00;
      end else if (ce) begin
        // R23: a stopped source loses its history
        if (!src_en[s]) begin
          settle_cnt[s] <= 8'h00;
        end else if (pin_rise[s] && settle_cnt[s] != 8'hFF) begin
          settle_cnt[s] <= settle_cnt[s] + 8'h01;
        end
      end
    end
  end

  logic hf_ready;
  logic hf_locked;
  logic hf_stable;
  logic mf_ready;
  logic lf_ready;
  // R16: running and usable
  assign hf_ready  = settle_cnt[PIN_HF] >= HF_READY_EDGES;
  // R17: within two percent
  assign hf_locked = settle_cnt[PIN_HF] >= HF_LOCK_EDGES;
  // R18: within half a percent
  assign hf_stable = settle_cnt[PIN_HF] >= HF_STABLE_EDGES;
  // R19: medium source usable
  assign mf_ready  = settle_cnt[PIN_MF] >= MF_READY_EDGES;
  assign lf_ready  = settle_cnt[PIN_LF] >= LF_READY_EDGES;

  // R14: postscaler chains on the high and medium sources
  logic [DIV_W-1:0] hf_div_reg;
  logic [DIV_W-1:0] mf_div_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hf_div_reg <= '0;
      mf_div_reg <= '0;
    end else if (ce) begin
      if (pin_rise[PIN_HF]) begin
        hf_div_reg <= hf_div_reg + 1'b1;
      end
      if (pin_rise[PIN_MF]) begin
        mf_div_reg <= mf_div_reg + 1'b1;
      end
    end
  end

  function automatic logic route_level(input logic [5:0] rt, input logic [PIN_N-1:0] sy,
                                       input logic [DIV_W-1:0] hd, input logic [DIV_W-1:0] md);
    logic [DIV_W:0] chain;
    chain = '0;
    unique case (rt[5:4])
      INT_HF:  chain = {hd, sy[PIN_HF]};
      INT_MF:  chain = {md, sy[PIN_MF]};
      default: chain = {{DIV_W{1'b0}}, sy[PIN_LF]};
    endcase
    return chain[rt[3:0]];
  endfunction

  logic cur_lvl;
  logic new_lvl;
  logic cur_prev_reg;
  logic new_prev_reg;
  logic cur_fall;
  logic new_rise;
  logic tgt_ready;
  assign cur_lvl  = route_level(act_route_reg, pin_sync, hf_div_reg, mf_div_reg);
  assign new_lvl  = route_level(tgt_route_reg, pin_sync, hf_div_reg, mf_div_reg);
  assign cur_fall = cur_prev_reg & ~cur_lvl;
  assign new_rise = ~new_prev_reg & new_lvl;
  assign tgt_ready = (tgt_route_reg[5:4] == act_route_reg[5:4])
                     || (tgt_route_reg[5:4] == INT_HF && hf_ready)
                     || (tgt_route_reg[5:4] == INT_MF && mf_ready)
                     || (tgt_route_reg[5:4] == INT_LF && lf_ready);

  switch_e sw_state;

  // R22: glitch-free change of internal frequency
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sw_state       <= SW_IDLE;
      act_route_reg  <= {INT_MF, 4'h0};
      tgt_route_reg  <= {INT_MF, 4'h0};
      cur_prev_reg   <= 1'b0;
      new_prev_reg   <= 1'b0;
      internal_clock <= 1'b0;
    end else if (ce) begin
      cur_prev_reg <= cur_lvl;
      new_prev_reg <= new_lvl;
      unique case (sw_state)
        SW_IDLE: begin
          internal_clock <= cur_lvl;
          tgt_route_reg  <= req_route;
          // with the block unused there is no running clock to protect
          if (!int_mode) begin
            act_route_reg <= req_route;
          end else if (req_route != act_route_reg) begin
            sw_state <= SW_WAIT_READY;
          end
        end
        SW_WAIT_READY: begin
          internal_clock <= cur_lvl;
          if (tgt_ready) begin
            sw_state <= SW_WAIT_FALL;
          end
        end
        SW_WAIT_FALL: begin
          internal_clock <= cur_lvl;
          if (cur_fall) begin
            sw_state <= SW_WAIT_RISE;
          end
        end
        SW_WAIT_RISE: begin
          internal_clock <= new_rise;
          if (new_rise) begin
            act_route_reg <= tgt_route_reg;
            sw_state      <= SW_IDLE;
          end
        end
      endcase
      // block unused: a half-done switch is dropped, so no stopped source is awaited
      if (!int_mode) begin
        sw_state <= SW_IDLE;
      end
    end
  end

  // start-up sequencing
  logic crystal_mode;
  logic por_pend_reg;
  logic power_up_delay_ok;
  logic st_start;
  logic st_busy;
  assign crystal_mode = cfg_source_select == SRC_LP || cfg_source_select == SRC_XT
                        || cfg_source_select == SRC_HS;
  assign power_up_delay_ok  = !cfg_power_up_delay || power_up_done;
  // R2: after reset and delay, or on wake; R24: only crystal modes count
  assign st_start = crystal_mode && (wake_event || (por_pend_reg && power_up_delay_ok));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      por_pend_reg <= 1'b1;
      cpu_hold     <= 1'b1;
    end else if (ce) begin
      if (power_up_delay_ok) begin
        por_pend_reg <= 1'b0;
      end
      // R3: no instruction runs until counting ends
      cpu_hold <= (por_pend_reg && !power_up_delay_ok) || st_start || st_busy;
    end
  end

  osc_startup_counter #(
    .COUNT (START_COUNT)
  ) u_startup (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .start   (st_start),
    .tick    (pin_rise[PIN_PRI]),
    .busy    (st_busy)
  );

  // system source, multiplier and pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_clk_source         <= CLK_PRIMARY;
      pll_enable             <= 1'b0;
      pll_from_internal      <= 1'b0;
      primary_pin_released   <= 1'b0;
      secondary_pin_out      <= 1'b0;
      secondary_pin_oe_n     <= 1'b1;
      secondary_pin_released <= 1'b0;
    end else if (ce) begin
      // R9: R20: R10: R6: code 00 follows configuration, 01 timer, 1x internal
      if (scs_reg[SCS_INT_BIT]) begin
        sys_clk_source <= CLK_INTERNAL;
      end else if (scs_reg == SCS_TIMER) begin
        sys_clk_source <= CLK_TIMER;
      end else begin
        sys_clk_source <= (cfg_source_select == SRC_INT) ? CLK_INTERNAL : CLK_PRIMARY;
      end
      // R5: software bit only counts while configuration bit is clear
      pll_enable        <= cfg_pll_enable | spll_reg;
      // R4: multiplier input follows the default source kind
      pll_from_internal <= cfg_source_select == SRC_INT;
      // R8: primary pin free for general use in internal mode
      primary_pin_released <= cfg_source_select == SRC_INT;
      // R7: R8: secondary pin is the crystal drive only in crystal modes
      if (crystal_mode) begin
        secondary_pin_oe_n     <= 1'b1;
        secondary_pin_released <= 1'b0;
        secondary_pin_out      <= 1'b0;
      end else if (cfg_clock_out_enable) begin
        secondary_pin_oe_n     <= 1'b0;
        secondary_pin_released <= 1'b0;
        secondary_pin_out      <= (cfg_source_select == SRC_INT) ? internal_clock
                                                                 : pin_sync[PIN_PRI];
      end else begin
        secondary_pin_oe_n     <= 1'b1;
        secondary_pin_released <= 1'b1;
        secondary_pin_out      <= 1'b0;
      end
    end
  end

  // bus slave: one registered answer per request, a cycle after it is seen, unmapped reads zero
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      REG_CONTROL: begin
        rd_data[CTL_SCS_LSB +: 2] = scs_reg;
        rd_data[CTL_IFS_LSB +: 4] = ifs_reg;
        rd_data[CTL_PLL_BIT]      = spll_reg;
      end
      REG_STATUS: begin
        rd_data[ST_HF_READY]  = hf_ready;
        rd_data[ST_HF_LOCKED] = hf_locked;
        rd_data[ST_HF_STABLE] = hf_stable;
        rd_data[ST_MF_READY]  = mf_ready;
        rd_data[ST_LF_READY]  = lf_ready;
        rd_data[ST_STARTED]   = !cpu_hold;
        rd_data[ST_SWITCHING] = sw_state != SW_IDLE;
      end
      REG_TUNING: rd_data[5:0] = osc_tune;
      default:    rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
    end
  end

  a_pll_either_bit: assert property (@(posedge clk_sys) disable iff (rst) // R5
    ce && (cfg_pll_enable || spll_reg) |=> pll_enable) else $error("multiplier not enabled");

  a_hold_during_count: assert property (@(posedge clk_sys) disable iff (rst) // R3
    ce && st_busy |=> cpu_hold) else $error("processor released during count");

  a_no_count_bypass: assert property (@(posedge clk_sys) disable iff (rst) // R24
    st_start |-> crystal_mode) else $error("count started outside crystal mode");

  a_freq_reset: assert property (@(posedge clk_sys) // R21
    $fell(rst) |-> ifs_reg == IFS_RESET) else $error("frequency select reset wrong");

  a_hf_enable_cond: assert property (@(posedge clk_sys) disable iff (rst) // R15
    ce && $past(ce) && hf_enable |-> $past(int_mode))
    else $error("high source on outside internal mode");

  a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst) // R23
    ce && !hf_enable ##1 ce |=> !hf_ready) else $error("ready flag held after stop");

  a_stable_order: assert property (@(posedge clk_sys) disable iff (rst) // R18
    hf_stable |-> hf_locked && hf_ready) else $error("stable without lock");

  a_held_low: assert property (@(posedge clk_sys) disable iff (rst) // R22
    ce && sw_state == SW_WAIT_RISE && !new_rise |=> !internal_clock)
    else $error("clock not held low during switch");

  a_primary_release: assert property (@(posedge clk_sys) disable iff (rst) // R8
    ce && cfg_source_select == SRC_INT |=> primary_pin_released)
    else $error("primary pin kept in internal mode");

  a_select_internal: assert property (@(posedge clk_sys) disable iff (rst) // R10
    ce && scs_reg[SCS_INT_BIT] |=> sys_clk_source == CLK_INTERNAL)
    else $error("internal selection not taken");

endmodule
`default_nettype wire

// *** osc_ctrl_pkg.sv ***
// constants, types and the frequency routing table of the oscillator control block
package osc_ctrl_pkg;

  // start-up count of primary pin oscillations in crystal modes
  localparam int unsigned STARTUP_CYCLES = 1024;

  // default source configuration codes
  localparam logic [2:0] SRC_LP  = 3'h0;
  localparam logic [2:0] SRC_XT  = 3'h1;
  localparam logic [2:0] SRC_HS  = 3'h2;
  localparam logic [2:0] SRC_RC  = 3'h3;
  localparam logic [2:0] SRC_INT = 3'h4;

  // run-time selection codes
  localparam logic [1:0] SCS_DEFAULT = 2'h0;
  localparam logic [1:0] SCS_TIMER   = 2'h1;
  localparam int         SCS_INT_BIT = 1;

  localparam logic [3:0] IFS_RESET  = 4'h7;
  localparam logic [3:0] IFS_HF_LOW = 4'h3;
  localparam logic [5:0] TUNE_RESET = 6'h00;

  // register byte offsets
  localparam int         ADR_W       = 4;
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_TUNING  = 4'h8;

  // control fields
  localparam int CTL_SCS_LSB = 0;
  localparam int CTL_IFS_LSB = 2;
  localparam int CTL_PLL_BIT = 6;

  // status fields
  localparam int ST_HF_READY  = 0;
  localparam int ST_HF_LOCKED = 1;
  localparam int ST_HF_STABLE = 2;
  localparam int ST_MF_READY  = 3;
  localparam int ST_LF_READY  = 4;
  localparam int ST_STARTED   = 5;
  localparam int ST_SWITCHING = 6;

  // synchroniser lanes
  localparam int PIN_HF  = 0;
  localparam int PIN_MF  = 1;
  localparam int PIN_LF  = 2;
  localparam int PIN_PRI = 3;
  localparam int PIN_TMR = 4;
  localparam int PIN_N   = 5;

  localparam int DIV_W = 9;

  typedef enum logic [1:0] {
    CLK_PRIMARY  = 2'h0,
    CLK_TIMER    = 2'h1,
    CLK_INTERNAL = 2'h2
  } sys_src_e;

  typedef enum logic [1:0] {
    INT_LF = 2'h0,
    INT_MF = 2'h1,
    INT_HF = 2'h2
  } int_src_e;

  // returns {source, postscale shift}; nine codes divide the high source
  function automatic logic [5:0] int_route(input logic [3:0] code);
    logic [5:0] r;
    r = {INT_LF, 4'h0};
    if (code[3]) begin
      r = {INT_HF, 1'b0, 3'h7 - code[2:0]};
    end else if (code == IFS_HF_LOW) begin
      r = {INT_HF, 4'h8};
    end else if (code[3:1] != 3'h0) begin
      r = {INT_MF, 4'h7 - code};
    end
    return r;
  endfunction

endpackage

// *** osc_startup_counter.sv ***
// start-up cycle counter: counts primary pin oscillations before release
`timescale 1ns/1ps
`default_nettype none
module osc_startup_counter
  import osc_ctrl_pkg::*;
#(
  parameter int unsigned COUNT = STARTUP_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic tick,
  output var  logic busy
);
  localparam int         W    = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  if (COUNT < 2) begin : g_bad_count
    $error("startup count must be at least 2");
  end

  logic [W-1:0] cnt_reg;

  // R2: restart counting
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy    <= 1'b0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (start) begin
        busy    <= 1'b1;
        cnt_reg <= '0;
      end else if (busy && tick) begin
        // R1: count full oscillations
        if (cnt_reg == LAST) begin
          busy <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end

  a_start_busy: assert property (@(posedge clk_sys) disable iff (rst) // R2
    ce && start |=> busy) else $error("counter did not start");

  a_count_end: assert property (@(posedge clk_sys) disable iff (rst) // R1
    ce && !start && busy && tick && cnt_reg == LAST |=> !busy)
    else $error("counter did not finish on last oscillation");

  a_no_early_end: assert property (@(posedge clk_sys) disable iff (rst) // R1
    ce && busy && cnt_reg != LAST |=> busy) else $error("counter ended early");

endmodule
`default_nettype wire

// *** osc_far_side.sv ***
// far-side model: crystal, timer crystal and the internal oscillator cells
`timescale 1ns/1ps
`default_nettype none
module osc_far_side (
  input  wire logic hf_enable,
  input  wire logic mf_enable,
  input  wire logic lf_enable,
  output var  logic primary_osc_pin,
  output var  logic timer_crystal_in_pin,
  output var  logic hf_osc_in,
  output var  logic mf_osc_in,
  output var  logic lf_osc_in
);
  logic ph;
  initial begin
    ph = 1'b0;
    forever #37 ph = ~ph;
  end
  // crystals oscillate whenever powered, not phase-locked to the bus clock
  assign primary_osc_pin      = ph;
  assign timer_crystal_in_pin = ~ph;
  // a disabled cell stops low, so its flags must drop
  assign hf_osc_in = hf_enable & ph;
  assign mf_osc_in = mf_enable & ~ph;
  assign lf_osc_in = lf_enable & ph;
endmodule
`default_nettype wire

// *** osc_clock_control_bench.sv ***
// self-checking bench for the oscillator source control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module osc_clock_control_bench
  import osc_ctrl_pkg::*;
();
  localparam int START = 4;
  logic clk_sys, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cpu_hold;
  logic cfg_pll_enable, cfg_clock_out_enable, cfg_power_up_delay, power_up_done;
  logic wake_event, hf_enable, mf_enable, lf_enable, pll_enable, pll_from_internal;
  logic primary_pin_released, primary_osc_pin, timer_crystal_in_pin;
  logic hf_osc_in, mf_osc_in, lf_osc_in;
  logic secondary_pin_oe_n, secondary_pin_released;
  logic [2:0]  cfg_source_select;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [1:0]  sys_clk_source;
  logic [5:0]  osc_tune;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int errors = 0, tests_run = 0, cycles = 0, n;
  typedef struct packed {
    logic [2:0] src; logic pll; logic [6:0] ctl; logic [1:0] sys; logic [3:0] exp;
  } row_s;
  // exp holds {pll_enable, pll_from_internal, primary_pin_released, hf_enable}
  row_s rows [7] = '{
    '{3'h0, 1'b0, 7'h1C, 2'h0, 4'h0},
    '{3'h4, 1'b0, 7'h7C, 2'h2, 4'hF},
    '{3'h4, 1'b1, 7'h3C, 2'h2, 4'hF},
    '{3'h3, 1'b0, 7'h01, 2'h1, 4'h0},
    '{3'h3, 1'b0, 7'h22, 2'h2, 4'h1},
    '{3'h0, 1'b0, 7'h0E, 2'h2, 4'h1},
    '{3'h5, 1'b0, 7'h1F, 2'h2, 4'h0}};
  osc_far_side far (.hf_enable, .mf_enable, .lf_enable, .primary_osc_pin,
    .timer_crystal_in_pin, .hf_osc_in, .mf_osc_in, .lf_osc_in);
  osc_clock_control #(.START_COUNT(START)) dut (.clk_sys, .rst, .ce, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .cfg_source_select, .cfg_pll_enable, .cfg_clock_out_enable, .cfg_power_up_delay,
    .power_up_done, .wake_event, .primary_osc_pin, .timer_crystal_in_pin, .hf_osc_in,
    .mf_osc_in, .lf_osc_in, .cpu_hold, .hf_enable, .mf_enable, .lf_enable,
    .hf_loop_enable(), .osc_tune, .pll_enable, .pll_from_internal, .sys_clk_source,
    .internal_clock(), .primary_pin_released, .secondary_pin_out(),
    .secondary_pin_oe_n, .secondary_pin_released);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // one classic cycle; the answer edge is waited for, never assumed
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tick(1);
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    {rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wake_event} = 6'h30;
    {cfg_pll_enable, cfg_clock_out_enable, cfg_power_up_delay, power_up_done} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, cfg_source_select} = {8'h0F, 32'h0, 3'h0};
    tick(10);
    rst <= 1'b0;
    tick(1);
    bus(1'b0, REG_CONTROL, 32'h0);
    `CHK("control reset", 32'h0000001C, rd)
    bus(1'b1, 4'hC, 32'hFF);
    bus(1'b0, 4'hC, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    bus(1'b1, REG_TUNING, 32'h3F);
    `CHK("tuning out", 6'h3F, osc_tune)
    $display("registers done");
    foreach (rows[i]) begin
      cfg_source_select <= rows[i].src;
      cfg_pll_enable <= rows[i].pll;
      bus(1'b1, REG_CONTROL, {25'h0, rows[i].ctl});
      // a switch waits on a divided edge, so its length follows the history
      do bus(1'b0, REG_STATUS, 32'h0); while (rd[ST_SWITCHING] !== 1'b0);
      bus(1'b0, REG_CONTROL, 32'h0);
      `CHK("control back", {25'h0, rows[i].ctl}, rd)
      `CHK("system source", rows[i].sys, sys_clk_source)
      `CHK("enables", rows[i].exp, {pll_enable, pll_from_internal, primary_pin_released, hf_enable})
    end
    $display("rows done");
    cfg_source_select <= SRC_INT;
    bus(1'b1, REG_CONTROL, 32'h3E);
    tick(400);
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("flags up", 4'hF, rd[3:0])
    bus(1'b1, REG_CONTROL, 32'h1E);
    tick(40);
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK("flags after stop", 4'h8, rd[3:0])
    $display("flags done");
    cfg_source_select <= SRC_XT;
    cfg_power_up_delay <= 1'b1;
    rst <= 1'b1;
    tick(10);
    rst <= 1'b0;
    tick(30);
    `CHK("hold for power-up", 1'b1, cpu_hold)
    power_up_done <= 1'b1;
    n = 0;
    while (cpu_hold === 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
    `CHK("count length", 1'b1, n >= START * 74 / 25 && n < 500)
    wake_event <= 1'b1;
    tick(1);
    wake_event <= 1'b0;
    tick(2);
    #1;
    `CHK("hold on wake", 1'b1, cpu_hold)
    tick(100);
    `CHK("release after wake", 1'b0, cpu_hold)
    cfg_source_select <= SRC_RC;
    tick(2);
    wake_event <= 1'b1;
    tick(1);
    wake_event <= 1'b0;
    tick(3);
    #1;
    `CHK("no count in RC", 1'b0, cpu_hold)
    `CHK("secondary pin free", 2'h3, {secondary_pin_released, secondary_pin_oe_n})
    cfg_clock_out_enable <= 1'b1;
    tick(3);
    `CHK("secondary pin drives", 2'h0, {secondary_pin_released, secondary_pin_oe_n})
    $display("start-up done");
    ce <= 1'b0;
    cfg_pll_enable <= 1'b1;
    tick(4);
    `CHK("frozen by enable", 1'b0, pll_enable)
    ce <= 1'b1;
    tick(3);
    `CHK("config multiplier", 1'b1, pll_enable)
    $display("clock enable done");
    end_of_test();
  end
endmodule
`default_nettype wire
